// File: hdl/ldma_engine.v
`timescale 1ns/100ps
`include "ldma_defs.vh"
// How it works
// - A channel idles until its peripheral pulls its ready request low.
// - A ready request raises the request output, driving the bus request low.
// - After grant, high address enable turns on the external latch.
// - High address byte goes out on data bus, latched by address strobe.
// - Address strobe also starts the dynamic memory cycle.
// - Memory wait ready derived from the strobe stretches the cycle.
// - After the memory delay, acknowledge says a valid character is on bus.
// - While owning buses, engine only pulses acknowledge; the peripheral takes the character itself.
// - After each write, release enable and hold, then await next request.
// - Memory and peripherals answer exactly as for processor cycles.
// - Parallel port served with the same request and acknowledge handshake.
// - Nine channels, one for each output port.
module ldma_engine (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Channel programming
  input wire LOAD_STB,
  input wire [3:0] LOAD_CHAN,
  input wire [1:0] LOAD_FIELD,
  input wire [15:0] LOAD_DATA,
  // Peripheral handshake, channel 8 is the parallel port
  input wire [8:0] TX_READY_REQUEST_N,
  output reg [8:0] TRANSFER_ACKNOWLEDGE,
  // Processor bus arbitration
  output reg DMA_REQUEST_OUT,
  output reg CPU_BUS_REQUEST_N,
  output reg HOLD_REQUEST,
  input wire CPU_BUS_GRANT_N,
  // Local bus
  output reg HIGH_ADDR_ENABLE,
  output reg ADDR_LATCH_STROBE,
  output reg [7:0] LOCAL_ADDR_OUT,
  output reg [7:0] LOCAL_DATA_OUT,
  output reg LOCAL_BUS_OE,
  input wire MEMORY_WAIT_READY,
  // Status
  output reg [8:0] CHANNEL_DONE
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [8:0] rdy_m;
  reg [8:0] rdy_s;
  reg gnt_m;
  reg gnt_s;
  reg wr_m;
  reg wr_s;
  // Reset to idle pin levels so no false request follows reset
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdy_m <= 9'h1FF;
      rdy_s <= 9'h1FF;
      gnt_m <= 1'h1;
      gnt_s <= 1'h1;
      wr_m <= 1'h0;
      wr_s <= 1'h0;
    end else begin
      rdy_m <= TX_READY_REQUEST_N;
      rdy_s <= rdy_m;
      gnt_m <= CPU_BUS_GRANT_N;
      gnt_s <= gnt_m;
      wr_m <= MEMORY_WAIT_READY;
      wr_s <= wr_m;
    end
  end
  // ****************************************
  // Channel registers
  // ****************************************
  reg [15:0] ch_addr [0:8];
  reg [15:0] ch_count [0:8];
  reg [1:0] ch_mode [0:8];
  reg [2:0] state;
  reg [3:0] cur;
  reg [7:0] dly;
  wire [8:0] armed;
  genvar g;
  generate
    for (g = 0; g < `LDMA_NCHAN; g = g + 1) begin : arm
      // Channel with nothing left or no read mode never requests the bus
      assign armed[g] = ~rdy_s[g] & (ch_mode[g] == `LDMA_MODE_READ) & ~CHANNEL_DONE[g];
    end
  endgenerate
  // Lowest port number wins; fixed priority is fine at character rates
  function [3:0] pick;
    input [8:0] v;
    integer i;
    begin
      pick = 4'h0;
      for (i = `LDMA_NCHAN - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          pick = i[3:0];
        end
      end
    end
  endfunction
  // One acknowledge line per port
  function [8:0] onehot;
    input [3:0] c;
    begin
      onehot = 9'h001 << c;
    end
  endfunction
  // ****************************************
  // State codes and memory delay
  // ****************************************
  // Codes match the shared header so traces read the same everywhere
  localparam [2:0] s_idle = `LDMA_S_IDLE;
  localparam [2:0] s_req = `LDMA_S_REQ;
  localparam [2:0] s_hiaddr = `LDMA_S_HIADDR;
  localparam [2:0] s_wait = `LDMA_S_WAIT;
  localparam [2:0] s_ack = `LDMA_S_ACK;
  localparam [2:0] s_rel = `LDMA_S_REL;
  localparam integer mem_cyc_full = `LDMA_MEM_CYC;
  // Cut to the counter width on purpose; the delay fits well inside it
  localparam [7:0] mem_cyc = mem_cyc_full[7:0];
  integer k;
  // ****************************************
  // Transfer sequencer
  // ****************************************
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= s_idle;
      cur <= 4'h0;
      dly <= 8'h00;
      DMA_REQUEST_OUT <= 1'h0;
      CPU_BUS_REQUEST_N <= 1'h1;
      HOLD_REQUEST <= 1'h0;
      HIGH_ADDR_ENABLE <= 1'h0;
      ADDR_LATCH_STROBE <= 1'h0;
      LOCAL_ADDR_OUT <= 8'h00;
      LOCAL_DATA_OUT <= 8'h00;
      LOCAL_BUS_OE <= 1'h0;
      TRANSFER_ACKNOWLEDGE <= 9'h000;
      CHANNEL_DONE <= 9'h1FF;
      for (k = 0; k < `LDMA_NCHAN; k = k + 1) begin
        ch_addr[k] <= 16'h0000;
        ch_count[k] <= 16'h0000;
        ch_mode[k] <= `LDMA_RST_MODE;
      end
    end else begin
      // Loads only while idle so a live transfer never sees a torn address
      if (LOAD_STB && state == s_idle && LOAD_CHAN < `LDMA_NCHAN) begin
        case (LOAD_FIELD)
          `LDMA_FLD_ADDR: ch_addr[LOAD_CHAN] <= LOAD_DATA;
          `LDMA_FLD_COUNT: begin
            ch_count[LOAD_CHAN] <= LOAD_DATA;
            CHANNEL_DONE[LOAD_CHAN] <= 1'h0;
          end
          `LDMA_FLD_MODE: ch_mode[LOAD_CHAN] <= LOAD_DATA[1:0];
          default: ch_mode[LOAD_CHAN] <= ch_mode[LOAD_CHAN];
        endcase
      end
      case (state)
        s_idle: begin
          // A load in the same clock wins; the start follows one clock later
          if (|armed && !LOAD_STB) begin
            cur <= pick(armed);
            DMA_REQUEST_OUT <= 1'h1;
            CPU_BUS_REQUEST_N <= 1'h0;
            HOLD_REQUEST <= 1'h1;
            state <= s_req;
          end
        end
        s_req: begin
          // Grant is seen two clocks late; the processor has floated by then
          if (!gnt_s) begin
            HIGH_ADDR_ENABLE <= 1'h1;
            LOCAL_BUS_OE <= 1'h1;
            LOCAL_DATA_OUT <= ch_addr[cur][15:8];
            LOCAL_ADDR_OUT <= ch_addr[cur][7:0];
            // Strobe doubles as the memory address strobe, as for processor cycles
            ADDR_LATCH_STROBE <= 1'h1;
            state <= s_hiaddr;
          end
        end
        s_hiaddr: begin
          ADDR_LATCH_STROBE <= 1'h0;
          dly <= mem_cyc;
          state <= s_wait;
        end
        s_wait: begin
          // Memory wait ready may stretch past the nominal delay
          if (dly != 8'h00) begin
            dly <= dly - 8'h01;
          end else if (wr_s) begin
            TRANSFER_ACKNOWLEDGE <= onehot(cur);
            state <= s_ack;
          end
        end
        s_ack: begin
          TRANSFER_ACKNOWLEDGE <= 9'h000;
          // Address wraps at the top of the 16-bit space
          ch_addr[cur] <= ch_addr[cur] + 16'h0001;
          ch_count[cur] <= ch_count[cur] - 16'h0001;
          // Count already zero: that was the last character
          if (ch_count[cur] == 16'h0000) begin
            CHANNEL_DONE[cur] <= 1'h1;
          end
          // Everything drops together so the processor gets a quiet bus
          HIGH_ADDR_ENABLE <= 1'h0;
          HOLD_REQUEST <= 1'h0;
          DMA_REQUEST_OUT <= 1'h0;
          CPU_BUS_REQUEST_N <= 1'h1;
          LOCAL_BUS_OE <= 1'h0;
          state <= s_rel;
        end
        s_rel: begin
          // Wait out grant and stale ready so one request gives one character
          if (gnt_s && rdy_s[cur]) begin
            state <= s_idle;
          end
        end
        default: state <= s_idle;
      endcase
    end
  end
endmodule

// File: hdl/ldma_defs.vh
`ifndef LDMA_DEFS_VH
`define LDMA_DEFS_VH
// ****************************************
// Sizes
// ****************************************
`define LDMA_NCHAN 9
`define LDMA_CHW 4
`define LDMA_AW 16
`define LDMA_DW 8
`define LDMA_CNTW 16
// ****************************************
// Channel load command fields
// ****************************************
`define LDMA_FLD_ADDR 2'h0
`define LDMA_FLD_COUNT 2'h1
`define LDMA_FLD_MODE 2'h2
`define LDMA_MODE_READ 2'h1
`define LDMA_RST_MODE 2'h0
// ****************************************
// States
// ****************************************
`define LDMA_S_IDLE 3'h0
`define LDMA_S_REQ 3'h1
`define LDMA_S_HIADDR 3'h2
`define LDMA_S_WAIT 3'h3
`define LDMA_S_ACK 3'h4
`define LDMA_S_REL 3'h5
// ****************************************
// Timing
// ****************************************
`define LDMA_CLK_MHZ 20
`define LDMA_MEM_DELAY_NS 500
`define LDMA_MEM_CYC ((`LDMA_MEM_DELAY_NS * `LDMA_CLK_MHZ + 999) / 1000)
`define LDMA_DLYW 8
`endif

// File: test/ldma_engine_chk_asserts.sv
`timescale 1ns/100ps
// ****************************************
// Engine port checks
// ****************************************
module ldma_engine_chk (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Handshake
  input wire [8:0] TX_READY_REQUEST_N,
  input wire [8:0] TRANSFER_ACKNOWLEDGE,
  input wire DMA_REQUEST_OUT,
  input wire CPU_BUS_REQUEST_N,
  input wire HOLD_REQUEST,
  input wire CPU_BUS_GRANT_N,
  // Local bus
  input wire HIGH_ADDR_ENABLE,
  input wire ADDR_LATCH_STROBE,
  input wire LOCAL_BUS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  req_ready_a: assert property ($rose(DMA_REQUEST_OUT) |->
    $past(TX_READY_REQUEST_N, 3) != 9'h1FF) else $error("request without ready");
  req_copy_a: assert property (CPU_BUS_REQUEST_N == !DMA_REQUEST_OUT)
    else $error("bus request not inverse");
  enable_grant_a: assert property ($rose(HIGH_ADDR_ENABLE) |->
    !CPU_BUS_GRANT_N && $past(!CPU_BUS_GRANT_N)) else $error("enable before grant");
  strobe_pulse_a: assert property (ADDR_LATCH_STROBE |->
    HIGH_ADDR_ENABLE ##1 !ADDR_LATCH_STROBE) else $error("strobe shape");
  ack_delay_a: assert property (ADDR_LATCH_STROBE |=> (TRANSFER_ACKNOWLEDGE == 9'h000)[*8]
    ##[3:60] (TRANSFER_ACKNOWLEDGE != 9'h000)) else $error("ack timing");
  ack_owned_a: assert property (|TRANSFER_ACKNOWLEDGE |->
    HOLD_REQUEST && HIGH_ADDR_ENABLE && $onehot(TRANSFER_ACKNOWLEDGE)) else $error("ack owner");
  bus_release_a: assert property (|TRANSFER_ACKNOWLEDGE |=>
    !HIGH_ADDR_ENABLE && !HOLD_REQUEST && !LOCAL_BUS_OE) else $error("no release");
  idle_quiet_a: assert property (!HIGH_ADDR_ENABLE |->
    !ADDR_LATCH_STROBE && !LOCAL_BUS_OE) else $error("drives without grant");
endmodule

// File: test/ldma_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Processor grant and memory wait model
// ****************************************
module ldma_host_model (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Arbitration and memory
  input wire CPU_BUS_REQUEST_N,
  input wire ADDR_LATCH_STROBE,
  input wire SLOW,
  output reg CPU_BUS_GRANT_N,
  output reg MEMORY_WAIT_READY
);
  reg [3:0] gcnt;
  reg [3:0] mcnt;
  // Grant only after the running cycle ends
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      gcnt <= 4'h0;
      CPU_BUS_GRANT_N <= 1'b1;
    end else if (CPU_BUS_REQUEST_N) begin
      gcnt <= 4'h0;
      CPU_BUS_GRANT_N <= 1'b1;
    end else if (gcnt == (SLOW ? 4'h6 : 4'h1)) CPU_BUS_GRANT_N <= 1'b0;
    else gcnt <= gcnt + 4'h1;
  end
  // Slow memory outlasts the fixed delay
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mcnt <= 4'h0;
      MEMORY_WAIT_READY <= 1'b0;
    end else if (ADDR_LATCH_STROBE) begin
      mcnt <= SLOW ? 4'hF : 4'h2;
      MEMORY_WAIT_READY <= 1'b0;
    end else if (mcnt != 4'h0) mcnt <= mcnt - 4'h1;
    else MEMORY_WAIT_READY <= 1'b1;
  end
endmodule

// File: test/local_dma_tx_handshake_tb.sv
`timescale 1ns/100ps
module local_dma_tx_handshake_tb;
  reg clk, rst, stb, slow;
  reg [3:0] ch;
  reg [1:0] fld;
  reg [15:0] dat;
  reg [8:0] rdy_n;
  wire [8:0] ack, done;
  wire [7:0] alo, ahi;
  wire rq, rq_n, hold, gnt_n, en, ls, oe, wr;
  integer failures = 0, check_count = 0;
  ldma_engine dut_u (.CLK(clk), .RESET(rst), .LOAD_STB(stb), .LOAD_CHAN(ch),
    .LOAD_FIELD(fld), .LOAD_DATA(dat), .TX_READY_REQUEST_N(rdy_n),
    .TRANSFER_ACKNOWLEDGE(ack), .DMA_REQUEST_OUT(rq), .CPU_BUS_REQUEST_N(rq_n),
    .HOLD_REQUEST(hold), .CPU_BUS_GRANT_N(gnt_n), .HIGH_ADDR_ENABLE(en),
    .ADDR_LATCH_STROBE(ls), .LOCAL_ADDR_OUT(alo), .LOCAL_DATA_OUT(ahi),
    .LOCAL_BUS_OE(oe), .MEMORY_WAIT_READY(wr), .CHANNEL_DONE(done));
  ldma_host_model host_u (.CLK(clk), .RESET(rst), .CPU_BUS_REQUEST_N(rq_n),
    .ADDR_LATCH_STROBE(ls), .SLOW(slow), .CPU_BUS_GRANT_N(gnt_n), .MEMORY_WAIT_READY(wr));
  task stop_test;
    begin
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task load(input [3:0] c, input [1:0] f, input [15:0] d);
    begin
      @(posedge clk); stb <= 1'b1; ch <= c; fld <= f; dat <= d;
      @(posedge clk); stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Bounded wait on strobe (0) or acknowledge (1)
  task wt(input integer w);
    integer i;
    begin
      i = 0;
      while ((w ? |ack : ls) !== 1'b1 && i < 80) begin @(posedge clk); #1; i = i + 1; end
      if ((w ? |ack : ls) !== 1'b1) begin failures = failures + 1; stop_test; end
    end
  endtask
  task xfer(input [3:0] c, input [15:0] a);
    begin
      @(posedge clk); rdy_n[c] <= 1'b0;
      wt(0);
      chk("addr", a, {ahi, alo});
      chk("own", 16'h0003, {14'h0000, en, oe});
      wt(1);
      chk("ack", 16'h0001 << c, {7'h00, ack});
      @(posedge clk); rdy_n[c] <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask
  task sc_unarmed;
    begin
      chk("done", 16'h01FF, {7'h00, done});
      @(posedge clk); rdy_n[5] <= 1'b0;
      repeat (20) @(posedge clk);
      chk("req", 16'h0000, {15'h0000, rq});
      rdy_n[5] <= 1'b1;
    end
  endtask
  task sc_serial;
    begin
      load(4'h3, 2'h0, 16'h12FF);
      load(4'h3, 2'h1, 16'h0001);
      load(4'h3, 2'h2, 16'h0001);
      xfer(4'h3, 16'h12FF);
      chk("done3", 16'h0000, {15'h0000, done[3]});
      slow <= 1'b1;
      xfer(4'h3, 16'h1300);
      chk("done3", 16'h0001, {15'h0000, done[3]});
    end
  endtask
  task sc_parallel;
    begin
      load(4'h8, 2'h0, 16'h0040);
      load(4'h8, 2'h1, 16'h0000);
      load(4'h8, 2'h2, 16'hA501);
      xfer(4'h8, 16'h0040);
      chk("done8", 16'h0001, {15'h0000, done[8]});
    end
  endtask
  task sc_reset;
    begin
      load(4'h2, 2'h1, 16'h0004);
      load(4'h2, 2'h2, 16'h0001);
      @(posedge clk); rdy_n[2] <= 1'b0;
      wt(0);
      @(posedge clk); rst <= 1'b1;
      @(posedge clk); #1;
      chk("rst_own", 16'h0000, {12'h000, rq, hold, en, oe});
      chk("rst_done", 16'h01FF, {7'h00, done});
      @(posedge clk); rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk("rst_req", 16'h0000, {15'h0000, rq});
      rdy_n[2] <= 1'b1;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'b1; stb = 1'b0; slow = 1'b0; ch = 4'h0; fld = 2'h0; dat = 16'h0000;
    rdy_n = 9'h1FF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sc_unarmed; sc_serial; sc_parallel; sc_reset;
    stop_test;
  end
endmodule
bind ldma_engine ldma_engine_chk chk_u (.CLK(CLK), .RESET(RESET),
  .TX_READY_REQUEST_N(TX_READY_REQUEST_N), .TRANSFER_ACKNOWLEDGE(TRANSFER_ACKNOWLEDGE),
  .DMA_REQUEST_OUT(DMA_REQUEST_OUT), .CPU_BUS_REQUEST_N(CPU_BUS_REQUEST_N),
  .HOLD_REQUEST(HOLD_REQUEST), .CPU_BUS_GRANT_N(CPU_BUS_GRANT_N),
  .HIGH_ADDR_ENABLE(HIGH_ADDR_ENABLE), .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
  .LOCAL_BUS_OE(LOCAL_BUS_OE));
